// ===== core_interrupt_sequencer.sv
// Core interrupt sequencer: latch, masking, priority, vectoring, stacks.
// Assumes sources are asynchronous pins; pipeline controls are on I_CLOCK.
//
// Functional notes
// - Reset and emulator interrupts ignore every mask
// - Masked latched request waits until unmasked
// - Global enable bit plus per-source mask bits
// - Reset leaves all maskable sources masked
// - Sync, latch, then eleven-cycle branch
// - Internal fetch branch equals eleven clocks
// - Latch cycle 2, push 3, fetch 4
// - One instruction completes, eleven aborted
// - Uninterruptible sequence postpones vectoring
// - Nested higher waits one handler instruction
// - Bit 0 highest, bit 31 lowest
// - Priority fixed in hardware
// - Simultaneous requests: highest served first
// - Software sets or clears latch except nonmaskables
// - Active handler latch bit cleared every cycle
// - Return stops per-cycle latch clearing
// - Clear-interrupt jump clears latch, pointer, pops status
// - After clear-interrupt jump source latches again
// - Delayed clear jump: two slots run, one aborted
// - Repeat request during handler is lost
// - PC stack empty after reset
// - Sources: arithmetic, stack, illegal, wrap, timer, system, soft
// - Respond only when running, unmasked, highest; enabled unless reset or emulator
// - Vectoring pushes PC, status, clears latch, updates pointer
// - Return branches, pops stacks, clears pointer bit
// - Vectors spaced four instructions apart
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_params.svh"
module core_interrupt_sequencer
   import irq_seq_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RSTN,
   input wire logic [`IRQ_NUM-1:0] I_IRQ,
   input wire logic I_RUNNING,
   input wire logic I_UNINTERRUPTIBLE,
   input wire logic I_HANDLER_INSTR_DONE,
   input wire logic [`ADDR_W-1:0] I_PC,
   input wire logic [31:0] I_ASTAT,
   input wire logic I_RTI,
   input wire logic I_JUMP_CLEAR_INTERRUPT,
   input wire logic I_JUMP_CLEAR_INTERRUPT_DB,
   input wire logic [`REG_ADDR_W-1:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   output logic O_FETCH_STALL,
   output logic [`ADDR_W-1:0] O_VECTOR,
   output logic O_VECTOR_FETCH,
   output logic O_ABORT,
   output logic O_ABORT_CI_SLOT,
   output logic [`ADDR_W-1:0] O_RETURN_ADDR,
   output logic O_RETURN,
   output logic [31:0] O_MODE_RESTORE,
   output logic [`STK_PTR_W-1:0] O_PC_STACK_DEPTH
);
   logic [31:0] irq_s1_q, irq_s2_q, irq_prev_q;
   logic [31:0] interrupt_latch_reg_q, interrupt_mask_reg_q;
   logic [31:0] nesting_mask_pointer_reg_q, mode_control_reg_q;
   logic [31:0] active_q;
   logic [31:0] rise, eligible, nest_block, latch_d, latch_clear;
   logic [31:0] sel_onehot;
   logic [`IRQ_IDX_W-1:0] sel_idx, cur_idx_q;
   logic sel_valid, take, nest_wait_q;
   seq_state_e state_q;
   logic [`CNT_W-1:0] cnt_q;
   logic [`ADDR_W-1:0] pc_stk_q [`STK_DEPTH];
   status_frame_s st_stk_q [`STK_DEPTH];
   logic [`STK_PTR_W-1:0] pc_sp_q, st_sp_q;
   logic [`ADDR_W-1:0] ret_pc;
   logic [`STK_PTR_W-1:0] pc_top, st_top;
   logic global_irq_enable, nesting_enable_bit, wr_latch;
   logic [31:0] active_clr;

   assign global_irq_enable = mode_control_reg_q[`MODE_IRPT_EN];
   assign nesting_enable_bit = mode_control_reg_q[`MODE_NEST_EN];
   assign pc_top = pc_sp_q - `STK_PTR_ONE;
   assign st_top = st_sp_q - `STK_PTR_ONE;
   assign ret_pc = pc_stk_q[pc_top[2:0]];
   assign wr_latch = I_WR && (I_ADDR == `REG_LATCH);

   // Pins cross domains through two flops before anything reads them
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         irq_s1_q <= `IRQ_ZERO32;
         irq_s2_q <= `IRQ_ZERO32;
         irq_prev_q <= `IRQ_ZERO32;
      end else begin
         irq_s1_q <= I_IRQ;
         irq_s2_q <= irq_s1_q;
         irq_prev_q <= irq_s2_q;
      end
   end

   // Edge-latched requests; sources cover every documented class
   assign rise = irq_s2_q & ~irq_prev_q;

   // Pointer bits mask every maskable source at or below the highest-priority active level
   always_comb begin
      nest_block = `IRQ_ZERO32;
      for (int i = `IRQ_NUM - 1; i >= 0; i--) begin
         if (nesting_mask_pointer_reg_q[i]) begin
            nest_block = `IRQ_ZERO32;
            for (int j = i; j < `IRQ_NUM; j++) nest_block[j] = 1'b1;
         end
      end
      if (!nesting_enable_bit && (nesting_mask_pointer_reg_q != `IRQ_ZERO32))
         nest_block = ~`IRQ_NMI_MASK;
      nest_block = nest_block & ~`IRQ_NMI_MASK;
   end

   // Mask gating: global enable and per-source mask, nonmaskables bypass
   always_comb begin
      eligible = interrupt_latch_reg_q & ~nest_block &
         ((interrupt_mask_reg_q & {32{global_irq_enable}}) | `IRQ_NMI_MASK);
   end

   // Fixed priority, lowest index wins
   always_comb begin
      sel_idx = `IRQ_POS_RESET;
      sel_valid = 1'b0;
      sel_onehot = `IRQ_ZERO32;
      for (int i = `IRQ_NUM - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            sel_idx = i[`IRQ_IDX_W-1:0];
            sel_valid = 1'b1;
         end
      end
      if (sel_valid) sel_onehot[sel_idx] = 1'b1;
   end

   // Wait out uninterruptible spans and the first nested handler instruction
   assign take = sel_valid && (state_q == ST_IDLE) && I_RUNNING &&
      !I_UNINTERRUPTIBLE && !nest_wait_q;

   // Active handlers keep their latch bit cleared; a clear jump frees it
   assign active_clr = (I_JUMP_CLEAR_INTERRUPT || I_JUMP_CLEAR_INTERRUPT_DB) ?
      (active_q & ~(`IRQ_ZERO32 | (32'h1 << cur_idx_q))) : active_q;

   always_comb begin
      latch_d = interrupt_latch_reg_q | rise;
      if (wr_latch)
         latch_d = (I_WDATA & ~`IRQ_NMI_MASK) |
            (latch_d & `IRQ_NMI_MASK);
      latch_clear = active_clr | (take ? sel_onehot : `IRQ_ZERO32);
      if (I_JUMP_CLEAR_INTERRUPT || I_JUMP_CLEAR_INTERRUPT_DB)
         latch_clear = latch_clear | (32'h1 << cur_idx_q);
      latch_d = latch_d & ~latch_clear;
   end

   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) interrupt_latch_reg_q <= `IRQ_ZERO32;
      else interrupt_latch_reg_q <= latch_d;
   end

   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         interrupt_mask_reg_q <= `IRQ_MASK_RESET;
         mode_control_reg_q <= `MODE_RESET;
      end else if (I_WR) begin
         if (I_ADDR == `REG_MASK)
            interrupt_mask_reg_q <= I_WDATA | `IRQ_NMI_MASK;
         if (I_ADDR == `REG_MODE) mode_control_reg_q <= I_WDATA;
      end
   end

   // Nesting pointer and active set track handler entry and exit
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         nesting_mask_pointer_reg_q <= `IRQ_ZERO32;
         active_q <= `IRQ_ZERO32;
         cur_idx_q <= `IRQ_POS_RESET;
      end else if (take) begin
         nesting_mask_pointer_reg_q <= nesting_mask_pointer_reg_q |
            sel_onehot;
         active_q <= active_q | sel_onehot;
         cur_idx_q <= sel_idx;
      end else if (I_RTI) begin
         nesting_mask_pointer_reg_q <= nesting_mask_pointer_reg_q &
            ~(32'h1 << cur_idx_q);
         active_q <= active_q & ~(32'h1 << cur_idx_q);
      end else if (I_JUMP_CLEAR_INTERRUPT || I_JUMP_CLEAR_INTERRUPT_DB) begin
         nesting_mask_pointer_reg_q <= nesting_mask_pointer_reg_q &
            ~(32'h1 << cur_idx_q);
         active_q <= active_clr;
      end else if (I_WR && I_ADDR == `REG_MASKP) begin
         nesting_mask_pointer_reg_q <= I_WDATA;
      end
   end

   // A nested request is held until the new handler runs one instruction
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) nest_wait_q <= 1'b0;
      else if (state_q == ST_BRANCH && cnt_q == `CNT_ONE)
         nest_wait_q <= nesting_enable_bit;
      else if (I_HANDLER_INSTR_DONE) nest_wait_q <= 1'b0;
   end

   // Recognised in cycle 2, push in 3, fetch from 4, eleven branch cycles
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_q <= ST_IDLE;
         cnt_q <= `CNT_ZERO;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take) state_q <= ST_PUSH;
            end
            ST_PUSH: state_q <= ST_FETCH;
            ST_FETCH: begin
               state_q <= ST_BRANCH;
               cnt_q <= `CNT_BRANCH;
            end
            ST_BRANCH: begin
               cnt_q <= cnt_q - `CNT_ONE;
               if (cnt_q == `CNT_ONE) state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Stacks: PC pushed on vector, status pushed too; empty after reset
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pc_sp_q <= `STK_PTR_ZERO;
      end else if (state_q == ST_PUSH) begin
         pc_stk_q[pc_sp_q[2:0]] <= I_PC;
         pc_sp_q <= pc_sp_q + `STK_PTR_ONE;
      end else if (I_RTI && pc_sp_q != `STK_PTR_ZERO) begin
         pc_sp_q <= pc_top;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_sp_q <= `STK_PTR_ZERO;
      end else if (state_q == ST_PUSH) begin
         st_stk_q[st_sp_q[2:0]] <= '{astat: I_ASTAT,
            mode: mode_control_reg_q};
         st_sp_q <= st_sp_q + `STK_PTR_ONE;
      end else if ((I_RTI || I_JUMP_CLEAR_INTERRUPT || I_JUMP_CLEAR_INTERRUPT_DB) &&
         st_sp_q != `STK_PTR_ZERO) begin
         st_sp_q <= st_top;
      end
   end

   // Pipeline outputs, all registered
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_FETCH_STALL <= 1'b0;
         O_VECTOR <= `VEC_BASE;
         O_VECTOR_FETCH <= 1'b0;
         O_ABORT <= 1'b0;
         O_ABORT_CI_SLOT <= 1'b0;
         O_RETURN_ADDR <= `VEC_BASE;
         O_RETURN <= 1'b0;
         O_MODE_RESTORE <= `MODE_RESET;
         O_PC_STACK_DEPTH <= `STK_PTR_ZERO;
      end else begin
         O_FETCH_STALL <= (state_q != ST_IDLE) || take;
         O_VECTOR_FETCH <= (state_q == ST_PUSH);
         if (take)
            O_VECTOR <= `VEC_BASE + ({{(`ADDR_W-`IRQ_IDX_W){1'b0}}, sel_idx}
               << `VEC_SPACING_SHIFT);
         // One instruction finishes; the eleven behind it are squashed
         O_ABORT <= take;
         // Delayed clear jump squashes the instruction after its two slots
         O_ABORT_CI_SLOT <= I_JUMP_CLEAR_INTERRUPT_DB;
         O_RETURN <= I_RTI && pc_sp_q != `STK_PTR_ZERO;
         O_RETURN_ADDR <= ret_pc;
         if ((I_RTI || I_JUMP_CLEAR_INTERRUPT || I_JUMP_CLEAR_INTERRUPT_DB) &&
            st_sp_q != `STK_PTR_ZERO)
            O_MODE_RESTORE <= st_stk_q[st_top[2:0]].mode;
         O_PC_STACK_DEPTH <= pc_sp_q;
      end
   end

   // Register read port, data valid one cycle after the strobe
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) O_RDATA <= `IRQ_ZERO32;
      else if (I_RD) begin
         case (I_ADDR)
            `REG_LATCH: O_RDATA <= interrupt_latch_reg_q;
            `REG_MASK: O_RDATA <= interrupt_mask_reg_q;
            `REG_MASKP: O_RDATA <= nesting_mask_pointer_reg_q;
            `REG_MODE: O_RDATA <= mode_control_reg_q;
            `REG_STATUS: O_RDATA <= {27'h0, cur_idx_q};
            default: O_RDATA <= `IRQ_ZERO32;
         endcase
      end else O_RDATA <= `IRQ_ZERO32;
   end
endmodule
`default_nettype wire

// ===== irq_seq_params.svh
// Constants for the core interrupt sequencer: positions, resets, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef IRQ_SEQ_PARAMS_SVH
`define IRQ_SEQ_PARAMS_SVH
`define IRQ_NUM 32
`define IRQ_IDX_W 5
`define IRQ_POS_RESET 5'h00
`define IRQ_POS_EMU 5'h01
`define IRQ_POS_TIMER_HI 5'h02
`define IRQ_POS_ILLEGAL 5'h03
`define IRQ_POS_STACK 5'h04
`define IRQ_POS_SYSEVT 5'h05
`define IRQ_POS_CIRC 5'h06
`define IRQ_POS_ARITH_FIX 5'h07
`define IRQ_POS_ARITH_FLT 5'h08
`define IRQ_POS_TIMER_LO 5'h09
`define IRQ_POS_SOFT 5'h0a
`define IRQ_NMI_MASK 32'h0000_0003
`define IRQ_MASK_RESET 32'h0000_0003
`define IRQ_ZERO32 32'h0000_0000
`define ADDR_W 24
`define VEC_BASE 24'h00_0000
`define VEC_SPACING_SHIFT 2
`define LATCH_CYCLES_NS 10
`define BRANCH_INSTR_CYCLES 11
`define CLK_PERIOD_NS 10
`define BRANCH_CYCLES ((`BRANCH_INSTR_CYCLES * `CLK_PERIOD_NS) / `CLK_PERIOD_NS)
`define CNT_W 4
`define CNT_ONE 4'h1
`define CNT_ZERO 4'h0
`define CNT_BRANCH 4'hb
`define REG_ADDR_W 4
`define REG_LATCH 4'h0
`define REG_MASK 4'h1
`define REG_MASKP 4'h2
`define REG_MODE 4'h3
`define REG_STATUS 4'h4
`define MODE_IRPT_EN 0
`define MODE_NEST_EN 1
`define MODE_RESET 32'h0000_0000
`define STK_DEPTH 8
`define STK_PTR_W 4
`define STK_PTR_ZERO 4'h0
`define STK_PTR_ONE 4'h1
`endif

// ===== irq_seq_pkg.sv
// Types shared by the core interrupt sequencer.
// Assumes the constants header sits beside it.
`include "irq_seq_params.svh"
package irq_seq_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PUSH = 4'b0010,
      ST_FETCH = 4'b0100,
      ST_BRANCH = 4'b1000
   } seq_state_e;
   typedef struct packed {
      logic stall;
      logic [`ADDR_W-1:0] vector;
   } fetch_req_s;
   typedef struct packed {
      logic [31:0] astat;
      logic [31:0] mode;
   } status_frame_s;
endpackage

// ===== seq_monitor.sv
// Checker for the interrupt sequencer's port timing.
// Assumes binding to the design top; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_params.svh"
module seq_monitor (
   input wire logic I_CLOCK,
   input wire logic I_RSTN,
   input wire logic I_RD,
   input wire logic I_JUMP_CLEAR_INTERRUPT_DB,
   input wire logic [31:0] O_RDATA,
   input wire logic O_FETCH_STALL,
   input wire logic [`ADDR_W-1:0] O_VECTOR,
   input wire logic O_VECTOR_FETCH,
   input wire logic O_ABORT,
   input wire logic O_ABORT_CI_SLOT
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RSTN);
   sequence s_branch;
      O_FETCH_STALL [*8];
   endsequence
   sequence s_quiet;
      !O_VECTOR_FETCH [*8];
   endsequence
   rdata_idle_a: assert property (
      !$past(I_RD) |-> O_RDATA == 32'h0) else $error("stray read data");
   abort_fetch_a: assert property (
      O_ABORT |=> O_VECTOR_FETCH) else $error("fetch not after abort");
   fetch_cause_a: assert property (
      O_VECTOR_FETCH |-> $past(O_ABORT)) else $error("fetch without abort");
   abort_stall_a: assert property (
      O_ABORT |-> O_FETCH_STALL) else $error("abort without stall");
   stall_hold_a: assert property (
      O_VECTOR_FETCH |-> s_branch) else $error("branch stall too short");
   stall_end_a: assert property (
      O_VECTOR_FETCH |-> ##[9:20] !O_FETCH_STALL) else $error("stall stuck");
   vector_align_a: assert property (
      O_VECTOR_FETCH |-> O_VECTOR[1:0] == 2'b00 && O_VECTOR < 24'h80)
      else $error("vector off table");
   ci_slot_a: assert property (
      I_JUMP_CLEAR_INTERRUPT_DB |=> O_ABORT_CI_SLOT) else $error("slot not aborted");
   one_vector_a: assert property (
      O_VECTOR_FETCH |=> s_quiet) else $error("overlapping vectoring");
endmodule
bind core_interrupt_sequencer seq_monitor u_mon (.I_CLOCK(I_CLOCK),
   .I_RSTN(I_RSTN), .I_RD(I_RD), .I_JUMP_CLEAR_INTERRUPT_DB(I_JUMP_CLEAR_INTERRUPT_DB),
   .O_RDATA(O_RDATA), .O_FETCH_STALL(O_FETCH_STALL), .O_VECTOR(O_VECTOR),
   .O_VECTOR_FETCH(O_VECTOR_FETCH), .O_ABORT(O_ABORT),
   .O_ABORT_CI_SLOT(O_ABORT_CI_SLOT));
`default_nettype wire

// ===== irq_source_model.sv
// Interrupt sources: each fired pin rises and holds a few cycles.
// Assumes the bench fires pins right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module irq_source_model #(parameter int HOLD = 4) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [31:0] i_fire,
   output logic [31:0] o_irq
);
   logic [3:0] cnt_q [32];
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      for (int i = 0; i < 32; i++) begin
         if (!i_rst_n) begin
            o_irq[i] <= 1'b0;
            cnt_q[i] <= 4'h0;
         end else if (i_fire[i]) begin
            o_irq[i] <= 1'b1;
            cnt_q[i] <= 4'(HOLD);
         end else if (cnt_q[i] != 4'h0) begin
            cnt_q[i] <= cnt_q[i] - 4'h1;
         end else begin
            o_irq[i] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== core_interrupt_sequencer_tb.sv
// Self-checking bench for the interrupt sequencer.
// Assumes the design, its checker and the source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_params.svh"
module core_interrupt_sequencer_tb;
   logic clk = 1'b0, rst_n = 1'b0, run = 1'b1, unint = 1'b0, done = 1'b0;
   logic rti = 1'b0, jci = 1'b0, jcidb = 1'b0, wr = 1'b0, rd = 1'b0;
   logic rd_pend = 1'b0, stall, vfetch, abort, ret, abort_prev = 1'b0;
   logic [`ADDR_W-1:0] raddr;
   logic [3:0] addr = 4'h0, depth;
   logic [31:0] wdata = 32'h0, astat = 32'h0, fire = 32'h0, irq, rdata, r;
   logic [`ADDR_W-1:0] pc = 24'h0, vec;
   logic [31:0] rdq[$];
   logic [4:0] vecq[$];
   int fails = 0, checked = 0;
   irq_source_model src (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire),
      .o_irq(irq));
   core_interrupt_sequencer uut (.I_CLOCK(clk), .I_RSTN(rst_n),
      .I_IRQ(irq), .I_RUNNING(run), .I_UNINTERRUPTIBLE(unint),
      .I_HANDLER_INSTR_DONE(done), .I_PC(pc), .I_ASTAT(astat), .I_RTI(rti),
      .I_JUMP_CLEAR_INTERRUPT(jci), .I_JUMP_CLEAR_INTERRUPT_DB(jcidb), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_FETCH_STALL(stall),
      .O_VECTOR(vec), .O_VECTOR_FETCH(vfetch), .O_ABORT(abort),
      .O_ABORT_CI_SLOT(), .O_RETURN_ADDR(raddr), .O_RETURN(ret),
      .O_MODE_RESTORE(), .O_PC_STACK_DEPTH(depth));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      rdq.push_back(e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // Bits: handler done, return, clear jump, delayed clear jump
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      {done, rti, jci, jcidb} <= m;
      @(posedge clk);
      {done, rti, jci, jcidb} <= 4'h0;
   endtask
   task automatic raise(input logic [31:0] m);
      @(posedge clk);
      fire <= m;
      @(posedge clk);
      fire <= 32'h0;
   endtask
   // Waits for one expected vectoring to finish, then plays the handler
   task automatic service(input logic ci, input logic [31:0] refire);
      int n;
      n = vecq.size();
      for (int k = 0; k < 60 && ((n != 0 && vecq.size() >= n)
            || stall !== 1'b0); k++) @(posedge clk);
      pulse(4'h8);
      if (ci) pulse(4'h2);
      if (refire != 32'h0) begin
         raise(refire);
         cyc(6);
      end
      if (!ci) pulse(4'h4);
      cyc(3);
   endtask
   task automatic conclude();
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Sampled mid-cycle so registered outputs have settled
   always @(negedge clk) begin
      if (rd_pend) chk("read data", rdq.pop_front(), rdata);
      rd_pend = rd;
      if (abort_prev) chk("fetch after abort", 32'h1, {31'h0, vfetch});
      abort_prev = abort;
      if (ret === 1'b1) chk("return address", 32'(pc), 32'(raddr));
      if (vfetch === 1'b1 && vecq.size() == 0) begin
         fails++;
         $display("wrong value vector expected none seen %h", vec);
      end else if (vfetch === 1'b1) begin
         chk("vector", {25'h0, vecq.pop_front(), 2'b00}, 32'(vec));
      end
   end
   initial begin
      cyc(4000);
      fails++;
      conclude();
   end
   initial begin
      r = $urandom(32'h858a857d);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      pc <= 24'($urandom());
      astat <= $urandom();
      rreg(`REG_MASK, `IRQ_MASK_RESET);
      rreg(`REG_MODE, `MODE_RESET);
      rreg(`REG_LATCH, 32'h0);
      chk("stack depth", 32'h0, 32'(depth));
      vecq.push_back(5'h1);
      raise(32'h2);
      service(1'b0, 32'h0);
      r = $urandom();
      wreg(`REG_MASK, r);
      rreg(`REG_MASK, r | `IRQ_NMI_MASK);
      wreg(`REG_LATCH, r);
      rreg(`REG_LATCH, r & ~`IRQ_NMI_MASK);
      wreg(`REG_LATCH, 32'h0);
      rreg(4'hf, 32'h0);
      wreg(`REG_MASK, 32'h0);
      wreg(`REG_MODE, 32'h1);
      raise(32'h200);
      cyc(6);
      rreg(`REG_LATCH, 32'h200);
      vecq.push_back(5'h9);
      wreg(`REG_MASK, 32'hffff_ffff);
      service(1'b0, 32'h0);
      vecq.push_back(5'h7);
      vecq.push_back(5'h9);
      raise(32'h280);
      service(1'b0, 32'h0);
      service(1'b0, 32'h0);
      vecq.push_back(5'ha);
      raise(32'h400);
      service(1'b0, 32'h400);
      rreg(`REG_LATCH, 32'h0);
      vecq.push_back(5'h9);
      vecq.push_back(5'h9);
      raise(32'h200);
      service(1'b1, 32'h200);
      service(1'b0, 32'h0);
      unint <= 1'b1;
      raise(32'h100);
      cyc(10);
      vecq.push_back(5'h8);
      unint <= 1'b0;
      service(1'b0, 32'h0);
      run <= 1'b0;
      raise(32'h100);
      cyc(10);
      vecq.push_back(5'h8);
      run <= 1'b1;
      service(1'b0, 32'h0);
      pulse(4'h1);
      cyc(4);
      conclude();
   end
endmodule
`default_nettype wire
